// >>> design/rss_pkg.sv
package rss_pkg;

    localparam int DATA_W = 8;
    localparam int MSB = 7;
    localparam int LSB = 0;
    localparam int NIB_W = 4;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_ROTL_MEM = 5'h01,
        OP_ROTL_TO_WORK_REG = 5'h02,
        OP_ROTL_THROUGH_FLAG_MEM = 5'h03,
        OP_ROTL_THROUGH_FLAG_TO_WORK_REG = 5'h04,
        OP_ROTR_MEM = 5'h05,
        OP_ROTR_TO_WORK_REG = 5'h06,
        OP_ROTR_THROUGH_FLAG_MEM = 5'h07,
        OP_ROTR_THROUGH_FLAG_TO_WORK_REG = 5'h08,
        OP_SUBTRACT_WITH_BORROW = 5'h09,
        OP_SUBTRACT_WITH_BORROW_IMM = 5'h0a,
        OP_SUBTRACT_WITH_BORROW_TO_MEM = 5'h0b,
        OP_SUBTRACT = 5'h0c,
        OP_SUBTRACT_IMM = 5'h0d,
        OP_SUBTRACT_TO_MEM = 5'h0e,
        OP_DECREMENT_SKIP_ZERO = 5'h0f,
        OP_DECREMENT_SKIP_ZERO_TO_WORK_REG = 5'h10,
        OP_INCREMENT_SKIP_ZERO = 5'h11,
        OP_INCREMENT_SKIP_ZERO_TO_WORK_REG = 5'h12,
        OP_SET_BYTE = 5'h13,
        OP_SET_BIT = 5'h14,
        OP_SKIP_NONZERO_BIT = 5'h15,
        OP_SKIP_NONZERO = 5'h16,
        OP_SWAP = 5'h17
    } rss_op_t;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_DUMMY = 1'b1
    } rss_state_t;

endpackage : rss_pkg

// >>> design/rss_sub_if.sv
`timescale 1ns/1ns
interface rss_sub_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic borrow_in;
    logic [7:0] diff;
    logic no_borrow;
    logic half_no_borrow;
    logic overflow;
    logic signed_ge;

    modport user (
        output minuend,
        output subtrahend,
        output borrow_in,
        input diff,
        input no_borrow,
        input half_no_borrow,
        input overflow,
        input signed_ge
    );

    modport unit (
        input minuend,
        input subtrahend,
        input borrow_in,
        output diff,
        output no_borrow,
        output half_no_borrow,
        output overflow,
        output signed_ge
    );
endinterface : rss_sub_if

// >>> design/rss_sub.sv
`timescale 1ns/1ns
module rss_sub (
    rss_sub_if.unit sub // subtract operands and result flags
);
    logic [8:0] full;
    logic [4:0] low;

    // nine-bit difference: bit 8 set means a borrow came out of the top
    assign full = {1'b0, sub.minuend} - {1'b0, sub.subtrahend}
        - {8'h00, sub.borrow_in};
    assign low = {1'b0, sub.minuend[3:0]} - {1'b0, sub.subtrahend[3:0]}
        - {4'h0, sub.borrow_in};
    assign sub.diff = full[7:0];
    // carry holds "no borrow": clear when negative, set when zero or positive
    assign sub.no_borrow = ~full[8];
    assign sub.half_no_borrow = ~low[4];
    assign sub.overflow = (sub.minuend[rss_pkg::MSB] ^ sub.subtrahend[rss_pkg::MSB])
        & (full[rss_pkg::MSB] ^ sub.minuend[rss_pkg::MSB]);
    assign sub.signed_ge = ~(sub.overflow ^ full[rss_pkg::MSB]);
endmodule : rss_sub

// >>> design/rss_exec.sv
// What this block does
// - rotate operand left, bit 7 into bit 0, to memory or working register, no flags.
// - rotate left through carry; old carry into bit 0, bit 7 into carry.
// - rotate right, bit 0 into bit 7, to memory or working register, no flags.
// - rotate right through carry; old carry into bit 7, bit 0 into carry.
// - subtract with borrow: work minus operand minus inverted carry, six flags updated.
// - every subtraction clears carry when negative, sets it when zero or positive.
// - plain subtract: work minus operand, to work or memory, six flags updated.
// - decrement memory operand, write back, skip when new value zero, no flags.
// - decrement operand into working register, memory untouched, skip when zero.
// - increment memory operand, write back, skip when new value zero, no flags.
// - increment operand into working register, memory untouched, skip when zero.
// - a taken skip inserts one dummy cycle, so the skip costs two cycles.
// - set-byte writes all ones to memory, flags untouched.
// - set-bit forces selected memory bit to one, others kept, no flags.
// - bit test skips when selected bit is one, else proceeds, no flags.
// - byte test writes value back and skips when nonzero, no flags.
// - nibble swap exchanges low and high nibbles and stores back to memory.
`timescale 1ns/1ns
module rss_exec (
    input wire logic clk, // 100 MHz core clock
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic op_valid, // an operation is offered this cycle
    input wire logic [4:0] op_code, // operation select, rss_op_t encoding
    input wire logic [7:0] mem_rdata, // data memory operand, valid with op_valid
    input wire logic [7:0] imm_data, // immediate operand
    input wire logic [2:0] bit_sel, // bit index for bit operations
    output logic op_ready, // operation accepted when high with op_valid
    output logic mem_we, // one-cycle data memory write strobe
    output logic [7:0] mem_wdata, // data memory write value
    output logic [7:0] work_reg, // working register
    output logic carry_flag, // carry, set means no borrow on subtract
    output logic zero_flag, // zero
    output logic half_carry_flag, // low nibble carry or no borrow
    output logic signed_range_flag, // signed overflow
    output logic signed_compare_flag, // signed greater or equal
    output logic chained_zero_flag, // zero across chained subtracts
    output logic done, // one-cycle pulse when an operation completes
    output logic skip_pulse, // one-cycle pulse: next instruction is skipped
    output logic dummy_cycle // high during the inserted dummy cycle
);

    rss_pkg::rss_state_t state_reg;
    rss_pkg::rss_state_t state_next;
    rss_pkg::rss_op_t op;

    logic [7:0] work_reg_reg;
    logic [7:0] mem_wdata_reg;
    logic mem_we_reg;
    logic done_reg;
    logic skip_reg;
    logic carry_reg;
    logic zero_reg;
    logic half_carry_reg;
    logic signed_range_reg;
    logic signed_compare_reg;
    logic chained_zero_reg;

    logic take;
    logic [7:0] result;
    logic to_mem;
    logic to_work;
    logic skip_now;
    logic carry_upd;
    logic carry_new;
    logic arith_upd;
    logic use_borrow;
    logic [7:0] sub_rhs;
    logic [7:0] inc_val;
    logic [7:0] dec_val;

    rss_sub_if sub_bus ();

    function automatic logic [7:0] rotl8(input logic [7:0] v, input logic fill);
        rotl8 = {v[6:0], fill};
    endfunction : rotl8

    function automatic logic [7:0] rotr8(input logic [7:0] v, input logic fill);
        rotr8 = {fill, v[7:1]};
    endfunction : rotr8

    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == rss_pkg::BYTE_ZERO);
    endfunction : is_zero

    assign op = rss_pkg::rss_op_t'(op_code);
    assign op_ready = (state_reg == rss_pkg::ST_RUN);
    assign take = op_valid & op_ready;
    assign inc_val = mem_rdata + rss_pkg::BYTE_ONE;
    assign dec_val = mem_rdata - rss_pkg::BYTE_ONE;

    // immediate variants take the operand from the instruction word
    always_comb begin
        sub_rhs = mem_rdata;
        use_borrow = 1'b0;
        unique case (op)
            rss_pkg::OP_SUBTRACT_WITH_BORROW: begin
                use_borrow = 1'b1;
            end
            rss_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
                use_borrow = 1'b1;
                sub_rhs = imm_data;
            end
            rss_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
                use_borrow = 1'b1;
            end
            rss_pkg::OP_SUBTRACT_IMM: begin
                sub_rhs = imm_data;
            end
            default: begin
                sub_rhs = mem_rdata;
            end
        endcase
    end

    assign sub_bus.minuend = work_reg_reg;
    assign sub_bus.subtrahend = sub_rhs;
    // borrow in is the inverted carry for the borrow variants only
    assign sub_bus.borrow_in = use_borrow & ~carry_reg;

    rss_sub u_sub (
        .sub(sub_bus.unit)
    );

    always_comb begin
        result = mem_rdata;
        to_mem = 1'b0;
        to_work = 1'b0;
        skip_now = 1'b0;
        carry_upd = 1'b0;
        carry_new = carry_reg;
        arith_upd = 1'b0;
        unique case (op)
            rss_pkg::OP_NOP: begin
                result = mem_rdata;
            end
            rss_pkg::OP_ROTL_MEM: begin
                result = rotl8(mem_rdata, mem_rdata[rss_pkg::MSB]);
                to_mem = 1'b1;
            end
            rss_pkg::OP_ROTL_TO_WORK_REG: begin
                result = rotl8(mem_rdata, mem_rdata[rss_pkg::MSB]);
                to_work = 1'b1;
            end
            rss_pkg::OP_ROTL_THROUGH_FLAG_MEM: begin
                result = rotl8(mem_rdata, carry_reg);
                to_mem = 1'b1;
                carry_upd = 1'b1;
                carry_new = mem_rdata[rss_pkg::MSB];
            end
            rss_pkg::OP_ROTL_THROUGH_FLAG_TO_WORK_REG: begin
                result = rotl8(mem_rdata, carry_reg);
                to_work = 1'b1;
                carry_upd = 1'b1;
                carry_new = mem_rdata[rss_pkg::MSB];
            end
            rss_pkg::OP_ROTR_MEM: begin
                result = rotr8(mem_rdata, mem_rdata[rss_pkg::LSB]);
                to_mem = 1'b1;
            end
            rss_pkg::OP_ROTR_TO_WORK_REG: begin
                result = rotr8(mem_rdata, mem_rdata[rss_pkg::LSB]);
                to_work = 1'b1;
            end
            rss_pkg::OP_ROTR_THROUGH_FLAG_MEM: begin
                result = rotr8(mem_rdata, carry_reg);
                to_mem = 1'b1;
                carry_upd = 1'b1;
                carry_new = mem_rdata[rss_pkg::LSB];
            end
            rss_pkg::OP_ROTR_THROUGH_FLAG_TO_WORK_REG: begin
                result = rotr8(mem_rdata, carry_reg);
                to_work = 1'b1;
                carry_upd = 1'b1;
                carry_new = mem_rdata[rss_pkg::LSB];
            end
            rss_pkg::OP_SUBTRACT_WITH_BORROW,
            rss_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
                result = sub_bus.diff;
                to_work = 1'b1;
                arith_upd = 1'b1;
            end
            rss_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
                result = sub_bus.diff;
                to_mem = 1'b1;
                arith_upd = 1'b1;
            end
            rss_pkg::OP_SUBTRACT,
            rss_pkg::OP_SUBTRACT_IMM: begin
                result = sub_bus.diff;
                to_work = 1'b1;
                arith_upd = 1'b1;
            end
            rss_pkg::OP_SUBTRACT_TO_MEM: begin
                result = sub_bus.diff;
                to_mem = 1'b1;
                arith_upd = 1'b1;
            end
            rss_pkg::OP_DECREMENT_SKIP_ZERO: begin
                result = dec_val;
                to_mem = 1'b1;
                skip_now = is_zero(dec_val);
            end
            rss_pkg::OP_DECREMENT_SKIP_ZERO_TO_WORK_REG: begin
                result = dec_val;
                to_work = 1'b1;
                skip_now = is_zero(dec_val);
            end
            rss_pkg::OP_INCREMENT_SKIP_ZERO: begin
                result = inc_val;
                to_mem = 1'b1;
                skip_now = is_zero(inc_val);
            end
            rss_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK_REG: begin
                result = inc_val;
                to_work = 1'b1;
                skip_now = is_zero(inc_val);
            end
            rss_pkg::OP_SET_BYTE: begin
                result = rss_pkg::BYTE_ALL_ONES;
                to_mem = 1'b1;
            end
            rss_pkg::OP_SET_BIT: begin
                result = mem_rdata | (rss_pkg::BYTE_ONE << bit_sel);
                to_mem = 1'b1;
            end
            rss_pkg::OP_SKIP_NONZERO_BIT: begin
                skip_now = mem_rdata[bit_sel];
            end
            rss_pkg::OP_SKIP_NONZERO: begin
                // read and written back unchanged, as the real cycle does
                result = mem_rdata;
                to_mem = 1'b1;
                skip_now = ~is_zero(mem_rdata);
            end
            rss_pkg::OP_SWAP: begin
                result = {mem_rdata[rss_pkg::NIB_W-1:0],
                    mem_rdata[rss_pkg::MSB:rss_pkg::NIB_W]};
                to_mem = 1'b1;
            end
            default: begin
                // unknown codes complete as a no-op with no side effects
                result = mem_rdata;
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            rss_pkg::ST_RUN: begin
                if (take && skip_now) begin
                    state_next = rss_pkg::ST_DUMMY;
                end
            end
            rss_pkg::ST_DUMMY: begin
                state_next = rss_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= rss_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            work_reg_reg <= rss_pkg::WORK_RESET;
        end else if (take && to_work) begin
            work_reg_reg <= result;
        end
    end

    // memory writes are only issued by memory-destination variants
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_we_reg <= 1'b0;
            mem_wdata_reg <= rss_pkg::BYTE_ZERO;
        end else begin
            mem_we_reg <= take & to_mem;
            if (take && to_mem) begin
                mem_wdata_reg <= result;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_reg <= 1'b0;
            skip_reg <= 1'b0;
        end else begin
            done_reg <= take;
            skip_reg <= take & skip_now;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            carry_reg <= rss_pkg::FLAG_RESET;
        end else if (take && arith_upd) begin
            carry_reg <= sub_bus.no_borrow;
        end else if (take && carry_upd) begin
            carry_reg <= carry_new;
        end
    end

    // chained zero keeps a zero seen by earlier bytes of a borrow chain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            zero_reg <= rss_pkg::FLAG_RESET;
            half_carry_reg <= rss_pkg::FLAG_RESET;
            signed_range_reg <= rss_pkg::FLAG_RESET;
            signed_compare_reg <= rss_pkg::FLAG_RESET;
            chained_zero_reg <= rss_pkg::FLAG_RESET;
        end else if (take && arith_upd) begin
            zero_reg <= is_zero(sub_bus.diff);
            half_carry_reg <= sub_bus.half_no_borrow;
            signed_range_reg <= sub_bus.overflow;
            signed_compare_reg <= sub_bus.signed_ge;
            if (use_borrow) begin
                chained_zero_reg <= is_zero(sub_bus.diff) & chained_zero_reg;
            end else begin
                chained_zero_reg <= is_zero(sub_bus.diff);
            end
        end
    end

    assign work_reg = work_reg_reg;
    assign mem_we = mem_we_reg;
    assign mem_wdata = mem_wdata_reg;
    assign carry_flag = carry_reg;
    assign zero_flag = zero_reg;
    assign half_carry_flag = half_carry_reg;
    assign signed_range_flag = signed_range_reg;
    assign signed_compare_flag = signed_compare_reg;
    assign chained_zero_flag = chained_zero_reg;
    assign done = done_reg;
    assign skip_pulse = skip_reg;
    assign dummy_cycle = (state_reg == rss_pkg::ST_DUMMY);

endmodule : rss_exec

// >>> bench/rss_exec_assertions.sv
`timescale 1ns/1ns
module rss_exec_chk (
    input wire logic clk, // core clock
    input wire logic reset_n, // async reset
    input wire logic op_valid, // offer
    input wire logic [4:0] op_code, // select
    input wire logic [7:0] mem_rdata, // operand
    input wire logic [7:0] imm_data, // immediate
    input wire logic [2:0] bit_sel, // bit index
    input wire logic op_ready, // accept
    input wire logic mem_we, // write strobe
    input wire logic [7:0] mem_wdata, // write value
    input wire logic [7:0] work_reg, // working register
    input wire logic carry_flag, // carry
    input wire logic zero_flag, // zero
    input wire logic half_carry_flag, // half carry
    input wire logic signed_range_flag, // overflow
    input wire logic signed_compare_flag, // signed compare
    input wire logic chained_zero_flag, // chained zero
    input wire logic done, // completion
    input wire logic skip_pulse, // skip
    input wire logic dummy_cycle // dummy
);
    logic take;
    assign take = op_valid && op_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_skip; skip_pulse |-> (dummy_cycle && done && !op_ready) ##1 op_ready; endproperty
    a_skip: assert property (p_skip) else $error("skip without one dummy cycle");
    property p_rotl_work; take && op_code == rss_pkg::OP_ROTL_TO_WORK_REG |=> !mem_we
        && work_reg == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(carry_flag);
    endproperty
    a_rotl_work: assert property (p_rotl_work) else $error("left rotate to work wrong");
    property p_rotl_c; take && op_code == rss_pkg::OP_ROTL_THROUGH_FLAG_MEM |=> mem_we
        && carry_flag == $past(mem_rdata[7]) && mem_wdata[0] == $past(carry_flag); endproperty
    a_rotl_c: assert property (p_rotl_c) else $error("left rotate through carry wrong");
    property p_rotr_mem; take && op_code == rss_pkg::OP_ROTR_MEM |=> mem_we
        && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(work_reg);
    endproperty
    a_rotr_mem: assert property (p_rotr_mem) else $error("right rotate wrong");
    property p_rotr_c; take && op_code == rss_pkg::OP_ROTR_THROUGH_FLAG_TO_WORK_REG |=>
        carry_flag == $past(mem_rdata[0]) && work_reg[7] == $past(carry_flag); endproperty
    a_rotr_c: assert property (p_rotr_c) else $error("right rotate through carry wrong");
    property p_sub_c; take && op_code == rss_pkg::OP_SUBTRACT |=>
        carry_flag == ($past(work_reg) >= $past(mem_rdata)); endproperty
    a_sub_c: assert property (p_sub_c) else $error("subtract carry wrong");
    property p_dec; take && op_code == rss_pkg::OP_DECREMENT_SKIP_ZERO |=> mem_we
        && mem_wdata == $past(mem_rdata) - 8'h01 && skip_pulse == (mem_wdata == 8'h00);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement skip wrong");
    property p_set; take && op_code == rss_pkg::OP_SET_BYTE |=> mem_we && mem_wdata == 8'hff;
    endproperty
    a_set: assert property (p_set) else $error("set byte wrong");
    property p_setbit; take && op_code == rss_pkg::OP_SET_BIT |=> mem_we
        && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_sel))); endproperty
    a_setbit: assert property (p_setbit) else $error("set bit wrong");
    property p_bit; take && op_code == rss_pkg::OP_SKIP_NONZERO_BIT |=> !mem_we
        && skip_pulse == $past(mem_rdata[bit_sel]); endproperty
    a_bit: assert property (p_bit) else $error("bit test skip wrong");
    property p_swap; take && op_code == rss_pkg::OP_SWAP |=> mem_we
        && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}; endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");
endmodule : rss_exec_chk

bind rss_exec rss_exec_chk u_chk (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel),
    .op_ready(op_ready), .mem_we(mem_we), .mem_wdata(mem_wdata), .work_reg(work_reg),
    .carry_flag(carry_flag), .zero_flag(zero_flag), .half_carry_flag(half_carry_flag),
    .signed_range_flag(signed_range_flag), .signed_compare_flag(signed_compare_flag),
    .chained_zero_flag(chained_zero_flag), .done(done), .skip_pulse(skip_pulse),
    .dummy_cycle(dummy_cycle));

// >>> bench/tb_rotate_subtract_skip_ops.sv
`timescale 1ns/1ns
module tb_rotate_subtract_skip_ops;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic op_valid = 1'b0;
    logic [4:0] op_code = 5'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] imm_data = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic op_ready, mem_we, carry_flag, zero_flag, half_carry_flag, signed_range_flag;
    logic signed_compare_flag, chained_zero_flag, done, skip_pulse, dummy_cycle;
    logic [7:0] mem_wdata, work_reg, w_m;
    logic c_m, z_m, h_m, v_m, s_m, cz_m;
    logic [24:0] exp_q[$];
    logic [24:0] got, e;
    int n_fail = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    rss_exec dut (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
        .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel), .op_ready(op_ready),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .work_reg(work_reg), .carry_flag(carry_flag),
        .zero_flag(zero_flag), .half_carry_flag(half_carry_flag),
        .signed_range_flag(signed_range_flag), .signed_compare_flag(signed_compare_flag),
        .chained_zero_flag(chained_zero_flag), .done(done), .skip_pulse(skip_pulse),
        .dummy_cycle(dummy_cycle));

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic model(input logic [4:0] op, input logic [7:0] m, x, input logic [2:0] b);
        logic we, sk, bor, bin;
        logic [7:0] wd, o;
        logic [8:0] r;
        logic [4:0] h;
        we = 1'b0;
        sk = 1'b0;
        wd = 8'h00;
        o = (op == 5'h0a || op == 5'h0d) ? x : m;
        bor = op inside {5'h09, 5'h0a, 5'h0b};
        bin = bor & ~c_m;
        r = {1'b0, w_m} - {1'b0, o} - 9'(bin);
        h = {1'b0, w_m[3:0]} - {1'b0, o[3:0]} - 5'(bin);
        case (op)
            5'h01: begin we = 1'b1; wd = {m[6:0], m[7]}; end
            5'h02: w_m = {m[6:0], m[7]};
            5'h03: begin we = 1'b1; wd = {m[6:0], c_m}; c_m = m[7]; end
            5'h04: begin w_m = {m[6:0], c_m}; c_m = m[7]; end
            5'h05: begin we = 1'b1; wd = {m[0], m[7:1]}; end
            5'h06: w_m = {m[0], m[7:1]};
            5'h07: begin we = 1'b1; wd = {c_m, m[7:1]}; c_m = m[0]; end
            5'h08: begin w_m = {c_m, m[7:1]}; c_m = m[0]; end
            5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e: begin
                v_m = (w_m[7] ^ o[7]) & (r[7] ^ w_m[7]);
                s_m = ~(v_m ^ r[7]);
                z_m = r[7:0] == 8'h00;
                cz_m = bor ? z_m & cz_m : z_m;
                c_m = ~r[8];
                h_m = ~h[4];
                if (op == 5'h0b || op == 5'h0e) begin we = 1'b1; wd = r[7:0]; end
                else w_m = r[7:0];
            end
            5'h0f: begin we = 1'b1; wd = m - 8'h01; sk = wd == 8'h00; end
            5'h10: begin w_m = m - 8'h01; sk = w_m == 8'h00; end
            5'h11: begin we = 1'b1; wd = m + 8'h01; sk = wd == 8'h00; end
            5'h12: begin w_m = m + 8'h01; sk = w_m == 8'h00; end
            5'h13: begin we = 1'b1; wd = 8'hff; end
            5'h14: begin we = 1'b1; wd = m | (8'h01 << b); end
            5'h15: sk = m[b];
            5'h16: begin we = 1'b1; wd = m; sk = m != 8'h00; end
            5'h17: begin we = 1'b1; wd = {m[3:0], m[7:4]}; end
            default: ;
        endcase
        exp_q.push_back({we, wd, w_m, c_m, z_m, h_m, v_m, s_m, cz_m, sk, sk});
    endtask : model

    // request held until a negedge shows op_ready, so a dummy cycle is waited out
    task automatic issue(input logic [4:0] op, input logic [7:0] m, x, input logic [2:0] b);
        op_valid <= 1'b1;
        op_code <= op;
        mem_rdata <= m;
        imm_data <= x;
        bit_sel <= b;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            if (op_ready === 1'b1) break;
        end
        @(posedge clk);
        model(op, m, x, b);
    endtask : issue

    task automatic do_reset;
        reset_n <= 1'b0;
        op_valid <= 1'b0;
        repeat (16) @(posedge clk);
        samples_checked++;
        if ({work_reg, carry_flag, zero_flag, half_carry_flag, signed_range_flag,
             signed_compare_flag, chained_zero_flag, done, mem_we, skip_pulse,
             dummy_cycle, op_ready} !== 19'h1) begin
            n_fail++;
            $display("[FAIL] t=%0t reset state %h exp %h", $time, {work_reg, carry_flag,
                     zero_flag, half_carry_flag, signed_range_flag, signed_compare_flag,
                     chained_zero_flag, done, mem_we, skip_pulse, dummy_cycle, op_ready}, 19'h1);
        end
        reset_n <= 1'b1;
        {w_m, c_m, z_m, h_m, v_m, s_m, cz_m} = '0;
        exp_q.delete();
        @(posedge clk);
    endtask : do_reset

    always @(negedge clk) begin
        if (reset_n === 1'b1 && done === 1'b1) begin
            got = {mem_we, mem_we ? mem_wdata : 8'h00, work_reg, carry_flag, zero_flag,
                   half_carry_flag, signed_range_flag, signed_compare_flag,
                   chained_zero_flag, skip_pulse, dummy_cycle};
            e = exp_q.size() > 0 ? exp_q.pop_front() : ~got;
            samples_checked++;
            if (got !== e) begin
                n_fail++;
                $display("[FAIL] t=%0t got %h exp %h", $time, got, e);
            end
        end
    end

    initial begin
        repeat (10000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h7ccde467));
        do_reset();
        for (int o = 0; o < 32; o++) issue(5'(o), 8'h81, 8'h3c, 3'(o));
        $display("test sweep done");
        issue(5'h0f, 8'h01, 8'h00, 3'h0);
        issue(5'h10, 8'h01, 8'h00, 3'h0);
        issue(5'h11, 8'hff, 8'h00, 3'h0);
        issue(5'h12, 8'hff, 8'h00, 3'h0);
        issue(5'h11, 8'h05, 8'h00, 3'h0);
        issue(5'h15, 8'h08, 8'h00, 3'h3);
        issue(5'h15, 8'hfb, 8'h00, 3'h2);
        issue(5'h16, 8'h00, 8'h00, 3'h0);
        issue(5'h16, 8'h40, 8'h00, 3'h0);
        issue(5'h06, 8'h0a, 8'h00, 3'h0);
        issue(5'h0c, 8'h05, 8'h00, 3'h0);
        issue(5'h0c, 8'h01, 8'h00, 3'h0);
        issue(5'h09, 8'h00, 8'h00, 3'h0);
        issue(5'h0a, 8'h00, 8'h7f, 3'h0);
        issue(5'h0e, 8'h80, 8'h00, 3'h0);
        $display("test boundaries done");
        repeat (400) issue(5'($urandom_range(0, 31)), 8'($urandom), 8'($urandom), 3'($urandom));
        $display("test random done");
        issue(5'h0f, 8'h01, 8'h00, 3'h0);
        // let the skip report be compared and the dummy cycle end before reset lands
        op_valid <= 1'b0;
        @(posedge clk);
        do_reset();
        issue(5'h13, 8'h12, 8'h00, 3'h0);
        issue(5'h14, 8'h00, 8'h00, 3'h7);
        op_valid <= 1'b0;
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("[FAIL] t=%0t pending %h exp %h", $time, exp_q.size(), 0);
        end
        $display("test mid reset done");
        complete_run();
    end
endmodule : tb_rotate_subtract_skip_ops
